// *** inc/ssc_map.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH
`define SSC_ADDR_SAMPLING_CFG 8'h41
`define SSC_ADDR_GAIN 8'h42
`define SSC_ADDR_THRESHOLD 8'h43
`define SSC_ADDR_UNTOUCHED1 8'h50
`define SSC_ADDR_UNTOUCHED2 8'h51
`define SSC_ADDR_UNTOUCHED3 8'h52
`define SSC_RST_SAMPLING_CFG 8'h39
`define SSC_RST_GAIN 3'h2
`define SSC_RST_THRESHOLD 7'h40
`define SSC_RST_UNTOUCHED 16'h00c8
`define SSC_ACC_SEL_BIT 7
`define SSC_CNT_MSB 6
`define SSC_CNT_LSB 4
`define SSC_PER_MSB 3
`define SSC_PER_LSB 2
`define SSC_CYC_MSB 1
`define SSC_CYC_LSB 0
`define SSC_GAIN_MSB 2
`define SSC_THR_MSB 6
`define SSC_CLK_MHZ 20
`define SSC_SAMPLE_UNIT_US 320
`define SSC_CYCLE_UNIT_MS 35
`define SSC_SAMPLE_UNIT_CYC (`SSC_SAMPLE_UNIT_US * `SSC_CLK_MHZ)
`define SSC_CYCLE_UNIT_CYC (`SSC_CYCLE_UNIT_MS * 1000 * `SSC_CLK_MHZ)
`define SSC_DELTA_SHIFT 8
`define SSC_FULL_GAIN 8'h80
`define SSC_DELTA_MAX 8'h7f
`define SSC_BASE_NORM 4'd8
`define SSC_CYC_IDLE 24'hffffff
`endif

// *** inc/ssc_pkg.sv ***
// Types shared by the standby sensing control block
package ssc_pkg;
   typedef struct packed {
      logic accumulate_select;
      logic [2:0] standby_sample_count;
      logic [1:0] standby_sample_period;
      logic [1:0] standby_cycle_period;
   } ssc_cfg_t;

   typedef struct packed {
      logic valid;
      logic [15:0] count;
   } ssc_reading_t;

   typedef enum logic [1:0] {
      SSC_SLEEP = 2'b00,
      SSC_SAMPLE = 2'b01,
      SSC_ADVANCE = 2'b11
   } ssc_state_t;
endpackage : ssc_pkg

// *** logic/ssc_delta_calc.sv ***
// Delta count forming: sum or mean, gain scaling and threshold compare
`timescale 1ns/1ps
`include "ssc_map.svh"
module ssc_delta_calc (
   input wire logic clk_sys, // System clock
   input wire logic arst_n, // Async reset, active low
   input wire logic clear, // Start of a new measurement
   input wire logic add_en, // Reading to add
   input wire logic [15:0] count, // Raw reading
   input wire logic [15:0] base, // Untouched count of the channel
   input wire ssc_pkg::ssc_cfg_t cfg, // Sampling settings
   input wire logic [2:0] gain_code, // Gain field
   input wire logic [6:0] threshold, // Touch threshold
   output logic [7:0] delta, // Delta count of the measurement
   output logic touch // Delta above threshold
);
   import ssc_pkg::*;
   logic [22:0] sum;
   wire [16:0] diff = {1'b0, count} - {1'b0, base};
   wire [15:0] sample_delta = diff[16] ? 16'h0000 : diff[15:0];
   wire [22:0] mean = sum >> cfg.standby_sample_count;
   wire [22:0] chosen = cfg.accumulate_select ? sum : mean;
   wire [7:0] mult = `SSC_FULL_GAIN >> gain_code;
   wire [30:0] scaled = 31'(chosen * mult);
   wire [30:0] shifted = scaled >> `SSC_DELTA_SHIFT;
   wire [7:0] sat = (|shifted[30:7]) ? `SSC_DELTA_MAX : shifted[7:0];

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) sum <= 23'h0;
      else if (clear) sum <= 23'h0;
      else if (add_en) sum <= 23'(sum + {7'h0, sample_delta});
   end

   // Sum mode wraps in the 8-bit field, so big touches read falsely
   assign delta = cfg.accumulate_select ? shifted[7:0] : sat;
   assign touch = !delta[7] && (delta[6:0] > threshold);
endmodule : ssc_delta_calc

// *** logic/ssc_base_track.sv ***
// Untouched count tracking by an accumulating adder
`timescale 1ns/1ps
`include "ssc_map.svh"
module ssc_base_track (
   input wire logic clk_sys, // System clock
   input wire logic arst_n, // Async reset, active low
   input wire logic recal_en, // Calibration routine running
   input wire logic add_en, // Reading for this channel
   input wire logic [15:0] count, // Raw reading
   input wire logic [3:0] size_log2, // Log2 of sample size, 0 to 8
   output logic [15:0] base // Untouched count
);
   logic [23:0] acc;
   logic [8:0] n;
   wire [3:0] lg = (size_log2 > `SSC_BASE_NORM) ? `SSC_BASE_NORM : size_log2;
   wire [23:0] next_acc = 24'(acc + {8'h00, count});
   wire [8:0] next_n = 9'(n + 9'd1);
   wire full = (next_n == (9'd1 << lg));
   // Normalised so the upper 16 bits always hold the mean reading
   wire [23:0] norm = next_acc << (`SSC_BASE_NORM - lg);

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         acc <= 24'h0;
         n <= 9'h0;
         base <= `SSC_RST_UNTOUCHED;
      end else if (recal_en && add_en) begin
         if (full) begin
            base <= norm[23:8];
            acc <= 24'h0;
            n <= 9'h0;
         end else begin
            acc <= next_acc;
            n <= next_n;
         end
      end
   end
endmodule : ssc_base_track

// *** logic/ssc_top.sv ***
// Standby sensing control: registers, sensing cycle sequencer, results
// Behaviour
// - Average mode: delta from mean of samples
// - Sum mode: delta from sum, may overflow
// - Sample-count code selects 1 to 128 samples
// - All samples of one channel back to back
// - Sample-period code selects 320us to 2.56ms
// - Cycle-period code selects 35ms to 140ms
// - Cycle period also applies in Combo state
// - Sample at cycle start, then low power
// - Cycle lengthens when samples overrun it
// - Gain code scales delta 128x down to 1x
// - Touch when delta exceeds 7-bit threshold
// - Standby channels use standby settings only
// - Standby settings leave Active behaviour unchanged
// - Untouched counts read-only, reset C8h, recalibrated
// - Accumulate readings, take upper 16 bits
// - Clear accumulator after capturing the count
// - Separate shift field selects shown byte
`timescale 1ns/1ps
`include "ssc_map.svh"
module ssc_top #(
   parameter int unsigned SAMPLE_UNIT_CYCLES = `SSC_SAMPLE_UNIT_CYC, // 320us in clocks
   parameter int unsigned CYCLE_UNIT_CYCLES = `SSC_CYCLE_UNIT_CYC // 35ms in clocks
) (
   input wire logic clk_sys, // System clock, 20 MHz
   input wire logic arst_n, // Async reset, active low
   input wire logic reg_wr, // Register write strobe
   input wire logic reg_rd, // Register read strobe
   input wire logic [7:0] reg_addr, // Register address
   input wire logic [7:0] reg_wdata, // Write data
   output logic [7:0] reg_rdata, // Read data, valid cycle after reg_rd
   input wire logic standby_mode, // Device in Standby state
   input wire logic combo_mode, // Device in Combo state
   input wire logic [2:0] standby_chan_en, // Inputs monitored in Standby
   input wire logic recal_en, // Calibration routine active
   input wire logic [3:0] recal_size_log2, // Log2 of calibration sample size
   input wire logic [3:0] base_shift, // Shift for untouched count bytes
   input wire ssc_pkg::ssc_reading_t fe_reading, // Reading from front end
   output logic fe_sample_start, // Start one sample, one-cycle pulse
   output logic [1:0] fe_channel, // Channel being sampled
   output logic low_power, // Remainder of cycle in low power
   output logic cycle_start, // New sensing cycle, one-cycle pulse
   output logic [2:0] standby_touch, // Touch per input
   output logic [2:0][7:0] standby_delta // Delta count per input
);
   import ssc_pkg::*;

   ssc_cfg_t cfg;
   logic [2:0] gain_code;
   logic [6:0] threshold;
   ssc_state_t state;
   logic [23:0] smp_tmr;
   logic [23:0] cyc_cnt;
   logic [7:0] smp_idx;
   logic [1:0] ch;
   logic [2:0][15:0] base;
   logic [7:0] calc_delta;
   logic calc_touch;

   // Lowest enabled channel at or above a start index
   function automatic logic [2:0] find_chan(input logic [2:0] en, input logic [1:0] from);
      logic [2:0] res;
      res = 3'b100;
      for (int i = 2; i >= 0; i--) begin
         if (en[i] && (2'(i) >= from)) res = {1'b0, 2'(i)};
      end
      return res;
   endfunction : find_chan

   // Register decode
   wire wr_cfg = reg_wr && (reg_addr == `SSC_ADDR_SAMPLING_CFG);
   wire wr_gain = reg_wr && (reg_addr == `SSC_ADDR_GAIN);
   wire wr_thr = reg_wr && (reg_addr == `SSC_ADDR_THRESHOLD);
   // The untouched count addresses decode to no write at all
   wire [7:0] shown1 = 8'(base[0] >> base_shift);
   wire [7:0] shown2 = 8'(base[1] >> base_shift);
   wire [7:0] shown3 = 8'(base[2] >> base_shift);
   logic [7:0] rd_mux;
   always_comb begin
      unique case (reg_addr)
         `SSC_ADDR_SAMPLING_CFG: rd_mux = cfg;
         `SSC_ADDR_GAIN: rd_mux = {5'h00, gain_code};
         `SSC_ADDR_THRESHOLD: rd_mux = {1'b0, threshold};
         `SSC_ADDR_UNTOUCHED1: rd_mux = shown1;
         `SSC_ADDR_UNTOUCHED2: rd_mux = shown2;
         `SSC_ADDR_UNTOUCHED3: rd_mux = shown3;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cfg <= `SSC_RST_SAMPLING_CFG;
         gain_code <= `SSC_RST_GAIN;
         threshold <= `SSC_RST_THRESHOLD;
      end else begin
         if (wr_cfg) cfg <= reg_wdata;
         if (wr_gain) gain_code <= reg_wdata[`SSC_GAIN_MSB:0];
         if (wr_thr) threshold <= reg_wdata[`SSC_THR_MSB:0];
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) reg_rdata <= 8'h00;
      else if (reg_rd) reg_rdata <= rd_mux;
   end

   // Timing decode
   wire [23:0] sample_len = 24'(SAMPLE_UNIT_CYCLES) << cfg.standby_sample_period;
   wire [23:0] cycle_len = 24'(24'(CYCLE_UNIT_CYCLES)
      * (24'(cfg.standby_cycle_period) + 24'd1));
   wire [7:0] smp_last = 8'(9'(9'd1 << cfg.standby_sample_count) - 9'd1);

   // Only Standby or Combo runs this sequencer; Active sensing is elsewhere
   wire run = standby_mode || combo_mode;
   wire [2:0] first_ch = find_chan(standby_chan_en, 2'd0);
   wire [2:0] next_ch = (ch == 2'd2) ? 3'b100
      : find_chan(standby_chan_en, 2'(ch + 2'd1));
   // Cycle counter is only checked in sleep, so overruns stretch the cycle
   wire cycle_due = (state == SSC_SLEEP) && run
      && (cyc_cnt >= 24'(cycle_len - 24'd1));
   wire begin_cycle = cycle_due && !first_ch[2];
   wire smp_done = (smp_tmr >= 24'(sample_len - 24'd1));
   wire last_smp = smp_done && (smp_idx == smp_last);
   wire add_now = (state == SSC_SAMPLE) && fe_reading.valid;
   wire finish = (state == SSC_ADVANCE);

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state <= SSC_SLEEP;
         smp_tmr <= 24'h0;
         smp_idx <= 8'h00;
         ch <= 2'd0;
         fe_sample_start <= 1'b0;
      end else begin
         fe_sample_start <= 1'b0;
         unique case (state)
            SSC_SLEEP: begin
               if (begin_cycle) begin
                  state <= SSC_SAMPLE;
                  ch <= first_ch[1:0];
                  smp_tmr <= 24'h0;
                  smp_idx <= 8'h00;
                  fe_sample_start <= 1'b1;
               end
            end
            SSC_SAMPLE: begin
               if (!run) begin
                  state <= SSC_SLEEP;
               end else if (last_smp) begin
                  state <= SSC_ADVANCE;
               end else if (smp_done) begin
                  smp_tmr <= 24'h0;
                  smp_idx <= 8'(smp_idx + 8'd1);
                  fe_sample_start <= 1'b1;
               end else begin
                  smp_tmr <= 24'(smp_tmr + 24'd1);
               end
            end
            SSC_ADVANCE: begin
               if (next_ch[2] || !run) begin
                  state <= SSC_SLEEP;
               end else begin
                  state <= SSC_SAMPLE;
                  ch <= next_ch[1:0];
                  smp_tmr <= 24'h0;
                  smp_idx <= 8'h00;
                  fe_sample_start <= 1'b1;
               end
            end
            default: state <= SSC_SLEEP;
         endcase
      end
   end

   // Idle counter parks at its top so sensing starts at once when enabled
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) cyc_cnt <= `SSC_CYC_IDLE;
      else if (!run) cyc_cnt <= `SSC_CYC_IDLE;
      else if (begin_cycle) cyc_cnt <= 24'h0;
      else if (cyc_cnt != `SSC_CYC_IDLE) cyc_cnt <= 24'(cyc_cnt + 24'd1);
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) cycle_start <= 1'b0;
      else cycle_start <= begin_cycle;
   end

   assign fe_channel = ch;
   assign low_power = (state == SSC_SLEEP);

   ssc_delta_calc u_calc (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .clear(fe_sample_start && (smp_idx == 8'h00)),
      .add_en(add_now),
      .count(fe_reading.count),
      .base(base[ch]),
      .cfg(cfg),
      .gain_code(gain_code),
      .threshold(threshold),
      .delta(calc_delta),
      .touch(calc_touch)
   );

   // Results per channel, updated once the whole measurement is in
   generate
      for (genvar g = 0; g < 3; g++) begin : g_chan
         wire mine = (ch == 2'(g));
         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               standby_delta[g] <= 8'h00;
               standby_touch[g] <= 1'b0;
            end else if (!standby_chan_en[g]) begin
               standby_touch[g] <= 1'b0;
            end else if (finish && mine) begin
               standby_delta[g] <= calc_delta;
               standby_touch[g] <= calc_touch;
            end
         end

         ssc_base_track u_base (
            .clk_sys(clk_sys),
            .arst_n(arst_n),
            .recal_en(recal_en),
            .add_en(add_now && mine),
            .count(fe_reading.count),
            .size_log2(recal_size_log2),
            .base(base[g])
         );
      end
   endgenerate
endmodule : ssc_top

// *** sim/ssc_fe_model.sv ***
// Behavioural front end: one reading per sample request
`timescale 1ns/1ps
module ssc_fe_model (
   input wire logic clk_sys, // System clock
   input wire logic fe_sample_start, // Sample request
   input wire logic [1:0] fe_channel, // Channel sampled
   input wire logic [2:0][15:0] level, // Count each pad shows
   output ssc_pkg::ssc_reading_t fe_reading // Reading to the block
);
   import ssc_pkg::*;
   initial fe_reading = '0;
   always @(posedge clk_sys) begin
      fe_reading.valid <= fe_sample_start;
      // Off the valid cycle the data flips each clock between the last reading and its inverse
      fe_reading.count <= fe_sample_start ? level[fe_channel] : ~fe_reading.count;
   end
endmodule : ssc_fe_model

// *** sim/ssc_top_properties.sv ***
// Concurrent checks on the standby sensing control ports
`timescale 1ns/1ps
`include "ssc_map.svh"
module ssc_top_properties (
   input wire logic clk_sys, // System clock
   input wire logic arst_n, // Async reset, active low
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   input wire logic [7:0] reg_addr, // Address
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic [7:0] reg_rdata, // Read data
   input wire logic low_power, // Sleep flag
   input wire logic fe_sample_start, // Sample pulse
   input wire logic [1:0] fe_channel, // Channel sampled
   input wire logic cycle_start, // Cycle pulse
   input wire logic [2:0] standby_touch, // Touch flags
   input wire logic [2:0][7:0] standby_delta // Delta counts
);
   logic [6:0] thr_q;
   wire mapped = reg_addr inside {8'h41, 8'h42, 8'h43, 8'h50, 8'h51, 8'h52};
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) thr_q <= `SSC_RST_THRESHOLD;
      else if (reg_wr && reg_addr == `SSC_ADDR_THRESHOLD) thr_q <= reg_wdata[6:0];
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   lp_no_start_a: assert property (low_power |-> !fe_sample_start)
      else $error("sample start during low power");
   start_pulse_a: assert property (fe_sample_start |=> !fe_sample_start)
      else $error("sample start longer than one cycle");
   wake_cycle_a: assert property ($fell(low_power) |-> cycle_start)
      else $error("no cycle start after wake");
   cyc_cause_a: assert property (cycle_start |-> !low_power && fe_sample_start)
      else $error("cycle start without sampling");
   chan_steady_a: assert property (!low_power && $changed(fe_channel) |-> fe_sample_start)
      else $error("channel changed inside a measurement");
   chan_range_a: assert property (fe_channel != 2'h3)
      else $error("channel out of range");
   for (genvar g = 0; g < 3; g++) begin : g_touch
      touch_cause_a: assert property ($rose(standby_touch[g]) |->
         !standby_delta[g][7] && standby_delta[g][6:0] > thr_q)
         else $error("touch without delta above threshold");
   end
   unmapped_zero_a: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   reserved_zero_a: assert property (reg_rd && reg_addr == 8'h42 |=> reg_rdata[7:3] == 5'h00)
      else $error("reserved gain bits not zero");
   thr_read_a: assert property (reg_rd && reg_addr == 8'h43 |=>
      reg_rdata == {1'h0, $past(thr_q)})
      else $error("threshold read back wrong");
   cover property (cycle_start);
   cover property ($rose(standby_touch[0]));
   cover property (fe_sample_start && fe_channel == 2'h2);
endmodule : ssc_top_properties
bind ssc_top ssc_top_properties prop_u (.*);

// *** sim/ssc_top_tb.sv ***
// Self-checking testbench for the standby sensing control block
`timescale 1ns/1ps
module ssc_top_tb;
   import ssc_pkg::*;
   localparam int SU = 4;
   localparam int CU = 400;
   localparam logic [7:0] RA [7] = '{8'h41, 8'h42, 8'h43, 8'h50, 8'h51, 8'h52, 8'h60};
   localparam logic [7:0] RV [7] = '{8'h39, 8'h02, 8'h40, 8'hc8, 8'hc8, 8'hc8, 8'h00};
   logic clk_sys = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
   logic standby_mode = 1'h0, combo_mode = 1'h0, recal_en = 1'h0;
   logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata;
   logic [2:0] standby_chan_en = '0, standby_touch;
   logic [3:0] recal_size_log2 = '0, base_shift = '0;
   ssc_reading_t fe_reading;
   logic fe_sample_start, low_power, cycle_start, rd_seen = 1'h0, lp_q = 1'h1;
   logic [1:0] fe_channel, ch_q = '0;
   logic [2:0][7:0] standby_delta;
   logic [2:0][15:0] level = '0;
   logic [7:0] rq[$];
   logic [8:0] dq[$];
   int n_errors = 0, num_checks = 0, seed = 10, cnt = 0;
   ssc_top #(.SAMPLE_UNIT_CYCLES(SU), .CYCLE_UNIT_CYCLES(CU)) dut_u (.*);
   ssc_fe_model fe_u (.*);
   initial forever #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cnt <= cnt + 1;
      rd_seen <= reg_rd;
   end
   task automatic chk(input string nm, input logic [15:0] e, g);
      num_checks++;
      if (e !== g) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic chk_res(input logic [8:0] e, g);
      chk("delta", e[7:0], g[7:0]);
      chk("touch", e[8], g[8]);
   endtask : chk_res
   task automatic wr(input logic [7:0] a, d);
      @(negedge clk_sys);
      reg_wr = 1'h1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr = 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, e);
      @(negedge clk_sys);
      rq.push_back(e);
      reg_rd = 1'h1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd = 1'h0;
   endtask : rd
   task automatic wt(input logic v);
      for (int k = 0; k < 20000 && low_power !== v; k++) @(negedge clk_sys);
      if (low_power !== v) chk("wait", v, low_power);
   endtask : wt
   // Expected {touch, delta} of one measurement against an untouched count of c8h
   function automatic logic [8:0] exd(input logic [15:0] lv, input logic [7:0] c, g, t);
      logic [31:0] s;
      logic [7:0] v;
      s = (lv > 16'h00c8) ? 32'(lv - 16'h00c8) : 32'h0;
      // Sum mode keeps all N equal samples, average mode their mean
      if (c[7]) s = s << c[6:4];
      s = (s * (32'h80 >> g[2:0])) >> 8;
      v = c[7] ? s[7:0] : (s > 32'h7f ? 8'h7f : s[7:0]);
      return {!v[7] && v[6:0] > t[6:0], v};
   endfunction : exd
   always @(negedge clk_sys) begin
      if (rd_seen) chk("rdata", rq.pop_front(), reg_rdata);
      if (!lp_q && (low_power || fe_channel != ch_q))
         chk_res(dq.pop_front(), {standby_touch[ch_q], standby_delta[ch_q]});
      lp_q = low_power;
      ch_q = fe_channel;
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report
   initial begin
      #(60000 * 50);
      n_errors++;
      final_report();
   end
   initial begin
      logic [7:0] c, g, t;
      int t0, ls, sp;
      repeat (4) @(negedge clk_sys);
      arst_n = 1'h1;
      foreach (RA[k]) rd(RA[k], RV[k]);
      wr(8'h50, 8'h00);
      wr(8'h42, 8'hff);
      rd(8'h50, 8'hc8);
      rd(8'h42, 8'h07);
      base_shift = 4'h4;
      rd(8'h51, 8'h0c);
      base_shift = 4'h0;
      $display("register test done");
      for (logic [3:0] i = 0; i < 8; i++) begin
         wt(1'h1);
         standby_mode = 1'h0;
         combo_mode = 1'h0;
         c = {i[0], i[2:0], i[1:0], ~i[1:0]};
         g = 8'(i);
         t = 8'($random(seed)) & 8'h1f;
         standby_chan_en = 3'(i % 7 + 1);
         wr(8'h41, c);
         wr(8'h42, g);
         wr(8'h43, t);
         rd(8'h43, t);
         for (int k = 0; k < 3; k++) level[k] = 16'h00b8 + (16'($random(seed)) & 16'h01ff);
         repeat (2) for (int k = 0; k < 3; k++)
            if (standby_chan_en[k]) dq.push_back(exd(level[k], c, g, t));
         if (i[1]) combo_mode = 1'h1;
         else standby_mode = 1'h1;
         wt(1'h0);
         t0 = cnt;
         wt(1'h1);
         ls = cnt - t0;
         sp = $countones(standby_chan_en) * ((1 << i[2:0]) * (SU << i[1:0]) + 1);
         chk("span", 16'(sp), 16'(ls));
         wt(1'h0);
         sp = ls + 1 > CU * (4 - i[1:0]) ? ls + 1 : CU * (4 - i[1:0]);
         chk("period", 16'(sp), 16'(cnt - t0));
         wt(1'h1);
         $display("test %0d done", i);
      end
      standby_mode = 1'h0;
      combo_mode = 1'h0;
      wr(8'h41, 8'h10);
      standby_chan_en = 3'h7;
      recal_en = 1'h1;
      recal_size_log2 = 4'h1;
      for (int k = 0; k < 3; k++) level[k] = 16'h0040 + 16'(k);
      repeat (3) dq.push_back(9'h000);
      standby_mode = 1'h1;
      wr(8'h51, 8'hff);
      wt(1'h0);
      wt(1'h1);
      standby_mode = 1'h0;
      recal_en = 1'h0;
      foreach (RA[k]) if (k > 2 && k < 6) rd(RA[k], 8'h3d + 8'(k));
      base_shift = 4'h1;
      rd(8'h52, 8'h21);
      repeat (2) @(negedge clk_sys);
      chk("pending", 16'h0000, 16'(dq.size()));
      $display("recalibration test done");
      final_report();
   end
endmodule : ssc_top_tb
